// ---- hw/iop_pkg.sv ----
// package of constants and carrier types for the port, reset and clocking block
package iop_pkg;
  localparam int         CYC_PER_MC      = 12;        // oscillator clocks per machine cycle
  localparam logic [3:0] MC_LAST         = 4'h5;      // six divided states make one machine cycle
  localparam logic [3:0] PH_RESET        = 4'h0;
  localparam logic [7:0] PORT_RESET      = 8'hFF;     // port read values loaded under reset
  localparam int         RST_HOLD_MC     = 2;         // machine cycles reset must stay high
  localparam logic [4:0] RST_HOLD_LAST   = 5'h17;     // clocks of reset, less one, before full reset
  localparam int         CMP_POS_BIT     = 0;
  localparam int         CMP_NEG_BIT     = 1;
  localparam int         CMP_OUT_BIT     = 6;
  localparam int         RXD_BIT         = 0;
  localparam int         TXD_BIT         = 1;
  localparam int         IRQ0_BIT        = 2;
  localparam int         IRQ1_BIT        = 3;
  localparam int         TMR0_BIT        = 4;
  localparam int         TMR1_BIT        = 5;
  localparam logic [7:0] P3_GPIO_MASK    = 8'hBF;     // bit 6 is no general I/O

  typedef enum logic [1:0] {
    IOP_RUN  = 2'b00,
    IOP_IDLE = 2'b01,
    IOP_DOWN = 2'b11
  } iop_mode_t;

  // alternate functions seen by the core and peripherals
  typedef struct packed {
    logic ser_rx;
    logic ext_irq_zero_pin;
    logic ext_irq_one_pin;
    logic timer_zero_count_pin;
    logic timer_one_count_pin;
    logic comparator_positive_input;
    logic comparator_negative_input;
  } iop_alt_t;

  typedef struct packed {
    logic [7:0]  p1_sync1;
    logic [7:0]  p1_sync2;
    logic [7:0]  p3_sync1;
    logic [7:0]  p3_sync2;
    logic [7:0]  p1_rd;
    logic [7:0]  p3_rd;
    logic [7:0]  p1_oe;
    logic [7:0]  p3_oe;
    iop_alt_t    alt;
    logic        div2;
    logic [3:0]  phase;
    logic        mc_tick;
    logic [4:0]  hold;
    logic        full_reset;
    iop_mode_t   mode;
    logic        cpu_run;
    logic        periph_run;
    logic        osc_stop;
  } iop_state_t;
endpackage

// ---- hw/iop_ports.sv ----
// port pins, reset sequencing, machine-cycle clock and low-power modes
`timescale 1ns/1ps

// Summary of operation
// - reset high forces every port latch to one on the first clock edge, as reset is synchronous
// - full reset only after reset held high for two machine cycles
// - one machine cycle is twelve oscillator clocks; timing counts in that unit, except the reset hold, which counts clocks
// - oscillator feeds internal logic through a divide-by-two flip-flop; here only the phase counter uses it, all other flops run on the full clock
// - first port is 8-bit bidirectional; latch one makes pin a readable input
// - first port bits 0 and 1 are comparator positive and negative inputs
// - second port bit 6 is the comparator output, input only, no general I/O
// - second port bits 0-5 and 7 are pulled-up bidirectional pins
// - second port bit 0 is serial receive, bit 1 serial transmit
// - second port bits 2 and 3 are external interrupt 0 and 1 inputs
// - second port bits 4 and 5 are timer 0 and timer 1 count inputs
// - idle halts the cpu while ram, timers, serial and interrupts run
// - power-down stops the oscillator, keeps ram, disables all else
// - idle ends on any enabled interrupt or hardware reset
// - only hardware reset ends power-down; ram unchanged
module iop_ports (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic [7:0]        p1_latch,
  input  wire logic [7:0]        p3_latch,
  input  wire logic              ser_tx,
  input  wire logic              ser_tx_en,
  input  wire logic              cmp_out,
  input  wire logic              idle_req,
  input  wire logic              pdown_req,
  input  wire logic              irq_pending,
  input  wire logic [7:0]        p1_in,
  input  wire logic [7:0]        p3_in,
  output logic [7:0]             p1_out,
  output logic [7:0]             p1_oe,
  output logic [7:0]             p3_out,
  output logic [7:0]             p3_oe,
  output logic [7:0]             p1_rd,
  output logic [7:0]             p3_rd,
  output iop_pkg::iop_alt_t      alt,
  output logic                   osc_div2,
  output logic                   mc_tick,
  output logic                   full_reset,
  output logic                   cpu_run,
  output logic                   periph_run,
  output logic                   osc_stop
);

  iop_pkg::iop_state_t st;
  iop_pkg::iop_state_t next_st;
  logic [7:0]          p3_eff;

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    // pins pass two flops before anything reads them
    next_st.p1_sync1 = p1_in;
    next_st.p1_sync2 = st.p1_sync1;
    next_st.p3_sync1 = p3_in;
    next_st.p3_sync2 = st.p3_sync1;
    // latch one releases the pin; open-drain style pulls low only
    next_st.p1_oe = ~p1_latch;
    next_st.p3_oe = ~p3_eff & iop_pkg::P3_GPIO_MASK;
    next_st.div2 = ~st.div2;
    next_st.mc_tick = 1'b0;
    // phases advance on the divided clock only
    if (st.div2)
    begin
      if (st.phase == iop_pkg::MC_LAST)
      begin
        next_st.phase = iop_pkg::PH_RESET;
        next_st.mc_tick = 1'b1;
      end
      else
        next_st.phase = st.phase + 4'h1;
    end
    // inputs sampled once per machine cycle for the core
    if (st.mc_tick)
    begin
      next_st.p1_rd = st.p1_sync2;
      next_st.p3_rd = {cmp_out, st.p3_sync2[6:0]} & 8'hFF;
      next_st.p3_rd[iop_pkg::CMP_OUT_BIT] = cmp_out;
      next_st.p3_rd[7] = st.p3_sync2[7];
    end
    next_st.alt.comparator_positive_input = st.p1_sync2[iop_pkg::CMP_POS_BIT];
    next_st.alt.comparator_negative_input = st.p1_sync2[iop_pkg::CMP_NEG_BIT];
    next_st.alt.ser_rx = st.p3_sync2[iop_pkg::RXD_BIT];
    next_st.alt.ext_irq_zero_pin = st.p3_sync2[iop_pkg::IRQ0_BIT];
    next_st.alt.ext_irq_one_pin = st.p3_sync2[iop_pkg::IRQ1_BIT];
    next_st.alt.timer_zero_count_pin = st.p3_sync2[iop_pkg::TMR0_BIT];
    next_st.alt.timer_one_count_pin = st.p3_sync2[iop_pkg::TMR1_BIT];
    // reset hold counter counts clocks while reset stays high and saturates;
    // the machine-cycle clock is held under reset, so clocks are the unit here
    // and the limit is two machine cycles' worth of them
    next_st.full_reset = 1'b0;
    if (st.hold != iop_pkg::RST_HOLD_LAST + 5'h01)
      next_st.hold = st.hold + 5'h01;
    // mode machine
    case (st.mode)
      iop_pkg::IOP_RUN:
      begin
        if (pdown_req)
          next_st.mode = iop_pkg::IOP_DOWN;
        else if (idle_req)
          next_st.mode = iop_pkg::IOP_IDLE;
      end
      iop_pkg::IOP_IDLE:
      begin
        if (irq_pending)
          next_st.mode = iop_pkg::IOP_RUN;
      end
      iop_pkg::IOP_DOWN:
        next_st.mode = iop_pkg::IOP_DOWN;
      default:
        next_st.mode = iop_pkg::IOP_RUN;
    endcase
    // full reset comes after the mode machine so that it wins over it;
    // otherwise power-down would hold itself forever
    if (reset && st.hold == iop_pkg::RST_HOLD_LAST)
    begin
      next_st.full_reset = 1'b1;
      next_st.mode = iop_pkg::IOP_RUN;
    end
    next_st.cpu_run = (next_st.mode == iop_pkg::IOP_RUN);
    next_st.periph_run = (next_st.mode != iop_pkg::IOP_DOWN);
    next_st.osc_stop = (next_st.mode == iop_pkg::IOP_DOWN);
  end

  // serial transmit takes over bit 1 while the serial port drives it
  always_comb
  begin
    p3_eff = p3_latch;
    if (ser_tx_en)
      p3_eff[iop_pkg::TXD_BIT] = ser_tx;
  end

  // -----------------------------------------------------------------
  // state register; reset is synchronous, so latches recover on the
  // first edge with reset high; full reset waits two machine cycles.
  // the divider restarts under reset: without this it would never leave
  // its power-up unknown, as nothing else gives it a value
  // -----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      st <= next_st;
      st.p1_oe <= 8'h00;
      st.p3_oe <= 8'h00;
      st.p1_rd <= iop_pkg::PORT_RESET;
      st.p3_rd <= iop_pkg::PORT_RESET;
      st.cpu_run <= 1'b0;
      st.periph_run <= 1'b0;
      st.osc_stop <= 1'b0;
      st.div2 <= 1'b0;
      st.phase <= iop_pkg::PH_RESET;
      st.mc_tick <= 1'b0;
    end
    else
    begin
      st <= next_st;
      st.hold <= 2'h0;
      st.full_reset <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // outputs come straight from state flops, except p1_out and p3_out, which are tied low
  // -----------------------------------------------------------------
  assign p1_out     = 8'h00;
  assign p3_out     = 8'h00;
  assign p1_oe      = st.p1_oe;
  assign p3_oe      = st.p3_oe;
  assign p1_rd      = st.p1_rd;
  assign p3_rd      = st.p3_rd;
  assign alt        = st.alt;
  assign osc_div2   = st.div2;
  assign mc_tick    = st.mc_tick;
  assign full_reset = st.full_reset;
  assign cpu_run    = st.cpu_run;
  assign periph_run = st.periph_run;
  assign osc_stop   = st.osc_stop;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  latch_release_a: assert property (@(posedge clk) reset |=> (p1_oe == 8'h00 && p3_oe == 8'h00))
    else $error("port latches not forced to one under reset");
  reset_hold_a: assert property (@(posedge clk) $rose(full_reset) |-> $past(reset, 2))
    else $error("full reset without reset held");
  mc_spacing_a: assert property (@(posedge clk) disable iff (reset)
    mc_tick |=> (!mc_tick [*8]) ##1 (!mc_tick [*3]) ##1 mc_tick)
    else $error("machine cycle not twelve clocks");
  div_toggle_a: assert property (@(posedge clk) disable iff (reset)
    !$past(reset) |-> osc_div2 != $past(osc_div2))
    else $error("divide-by-two flop did not toggle");
  p3_six_a: assert property (@(posedge clk) !p3_oe[6])
    else $error("comparator output bit driven as gpio");
  p1_release_a: assert property (@(posedge clk) disable iff (reset)
    p1_latch == 8'hFF |=> p1_oe == 8'h00)
    else $error("released pin still driven");
  idle_cpu_a: assert property (@(posedge clk) disable iff (reset)
    (cpu_run && idle_req && !pdown_req) |=> (!cpu_run && periph_run))
    else $error("idle did not halt only the cpu");
  pdown_stay_a: assert property (@(posedge clk) disable iff (reset)
    (!periph_run && !cpu_run && $past(!periph_run) && !$past(reset)) |=> !periph_run)
    else $error("left power-down without reset");
  idle_exit_a: assert property (@(posedge clk) disable iff (reset)
    (!cpu_run && periph_run && irq_pending) |=> cpu_run)
    else $error("idle not left on interrupt");
  rd_hold_a: assert property (@(posedge clk) disable iff (reset)
    !$past(mc_tick) && !$past(reset) |-> $stable(p1_rd) && $stable(p3_rd))
    else $error("port read value changed between machine cycles");
  tx_drive_a: assert property (@(posedge clk) disable iff (reset)
    ser_tx_en |=> p3_oe[iop_pkg::TXD_BIT] == !$past(ser_tx))
    else $error("serial transmit level not on its pin");

  idle_seen_c:  cover property (@(posedge clk) !cpu_run && periph_run);
  idle_exit_c:  cover property (@(posedge clk) (!cpu_run && periph_run) ##1 cpu_run);
  mc_tick_c:    cover property (@(posedge clk) disable iff (reset) mc_tick);
  pdown_seen_c: cover property (@(posedge clk) !periph_run && !reset);
  reset_full_c: cover property (@(posedge clk) full_reset);
endmodule

// ---- testbench/iop_pins.sv ----
// far-side pin model: pullups, device sinks, external loads
`timescale 1ns/1ps
module iop_pins (
  input  wire logic [7:0] p1_oe,
  input  wire logic [7:0] p3_oe,
  input  wire logic [7:0] p1_ext_low,
  input  wire logic [7:0] p3_ext_low,
  output logic [7:0]      p1_in,
  output logic [7:0]      p3_in
);
  // wired-and: a line is high only when nobody sinks it, so pins never float
  assign p1_in = ~(p1_oe | p1_ext_low);
  assign p3_in = ~(p3_oe | p3_ext_low);
endmodule

// ---- testbench/io_ports_reset_and_clocking_test.sv ----
// self-checking bench for the port, reset and clocking block
`timescale 1ns/1ps
module io_ports_reset_and_clocking_test;
  logic clk, reset, ser_tx, ser_tx_en, cmp_out, idle_req, pdown_req, irq_pending;
  logic [7:0] p1_latch, p3_latch, p1_ext, p3_ext, p1_in, p3_in, p1_oe, p3_oe;
  logic [7:0] p1_rd, p3_rd, ex1, ex3, pin1, pin3;
  logic osc_div2, mc_tick, full_reset, cpu_run, periph_run, osc_stop;
  iop_pkg::iop_alt_t alt;
  logic [31:0] rnd = 32'h0189;
  int err_total = 0, num_checks = 0, cyc = 0, n, k;

  iop_ports u_dut (.clk(clk), .reset(reset), .p1_latch(p1_latch), .p3_latch(p3_latch),
    .ser_tx(ser_tx), .ser_tx_en(ser_tx_en), .cmp_out(cmp_out), .idle_req(idle_req),
    .pdown_req(pdown_req), .irq_pending(irq_pending), .p1_in(p1_in), .p3_in(p3_in),
    .p1_out(), .p1_oe(p1_oe), .p3_out(), .p3_oe(p3_oe), .p1_rd(p1_rd), .p3_rd(p3_rd),
    .alt(alt), .osc_div2(osc_div2), .mc_tick(mc_tick), .full_reset(full_reset),
    .cpu_run(cpu_run), .periph_run(periph_run), .osc_stop(osc_stop));
  iop_pins u_pins (.p1_oe(p1_oe), .p3_oe(p3_oe), .p1_ext_low(p1_ext), .p3_ext_low(p3_ext),
    .p1_in(p1_in), .p3_in(p3_in));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic cmp_val(input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected value at %0t: exp %h got %h", $time, exp, got);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
    #2;
  endtask
  // randomise port, serial and comparator drives; tx bit overrides the bit-1 latch when enabled
  task automatic shuffle();
    rnd = lfsr(rnd); p1_latch = rnd[7:0]; p3_latch = rnd[15:8]; p1_ext = rnd[23:16] & 8'h11;
    p3_ext = rnd[31:24] & 8'h3C; ser_tx = rnd[3]; ser_tx_en = rnd[9]; cmp_out = rnd[12];
    ex1 = ~p1_latch;
    ex3 = ~p3_latch & iop_pkg::P3_GPIO_MASK;
    if (ser_tx_en) ex3[iop_pkg::TXD_BIT] = ~ser_tx;
    pin1 = ~(ex1 | p1_ext);
    pin3 = ~(ex3 | p3_ext);
    pin3[iop_pkg::CMP_OUT_BIT] = cmp_out;
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic full_rst();
    reset = 1'b1;
    tick(1);
    cmp_val(8'h00, p1_oe | p3_oe);
    n = 1;
    while (full_reset !== 1'b1 && n < 100)
    begin
      tick(1);
      n++;
    end
    cmp_val(8'(iop_pkg::RST_HOLD_MC * iop_pkg::CYC_PER_MC), 8'(n));
    reset = 1'b0;
    tick(3);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // hang guard sized well above the whole sequence
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      conclude();
    end
  end

  initial
  begin
    reset = 1'b1; idle_req = 1'b0; pdown_req = 1'b0; irq_pending = 1'b0;
    shuffle();
    tick(4);
    reset = 1'b0;
    tick(2);
    full_rst();
    $display("test reset done");
    // latch to output enable, one clock later
    for (k = 0; k < 30; k++)
    begin
      shuffle();
      tick(1);
      cmp_val(ex1, p1_oe);
      cmp_val(ex3, p3_oe);
    end
    $display("test drive done");
    // pin reads land after a machine-cycle tick
    for (k = 0; k < 6; k++)
    begin
      shuffle();
      tick(60);
      n = 0;
      while (mc_tick !== 1'b1 && n < 40)
      begin
        tick(1);
        n++;
      end
      tick(2);
      cmp_val(pin1, p1_rd);
      cmp_val(pin3, p3_rd);
      cmp_val({1'b0, pin3[0], pin3[2], pin3[3], pin3[4], pin3[5], pin1[0], pin1[1]},
              8'(alt));
    end
    $display("test read done");
    // tick spacing and divider toggle
    n = 0;
    while (mc_tick !== 1'b1 && n < 40)
    begin
      tick(1);
      n++;
    end
    n = 0;
    k = 0;
    do
    begin
      ex1[0] = osc_div2;
      tick(1);
      n++;
      if (osc_div2 === ex1[0]) k++;
    end
    while (mc_tick !== 1'b1 && n < 40);
    cmp_val(8'(iop_pkg::CYC_PER_MC), 8'(n));
    cmp_val(8'h00, 8'(k));
    $display("test clock done");
    idle_req = 1'b1;
    tick(1);
    idle_req = 1'b0;
    tick(3);
    cmp_val(8'h01, {cpu_run, periph_run});
    irq_pending = 1'b1;
    tick(3);
    irq_pending = 1'b0;
    cmp_val(8'h03, {cpu_run, periph_run});
    pdown_req = 1'b1;
    tick(1);
    pdown_req = 1'b0;
    irq_pending = 1'b1;
    tick(10);
    cmp_val(8'h04, {osc_stop, cpu_run, periph_run});
    irq_pending = 1'b0;
    full_rst();
    cmp_val(8'h03, {osc_stop, cpu_run, periph_run});
    $display("test power done");
    conclude();
  end
endmodule
